// file: hdl/wdt_consts.svh
// Offsets, field positions, reset values and timing figures of the watchdog
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ==========================================================
// Register byte offsets on the APB side
`define WDT_CFG_OFS 12'h000
`define WDT_RCTL_OFS 12'h004
`define WDT_COUNT_OFS 12'h008
`define WDT_CMD_OFS 12'h00c

// ==========================================================
// Configuration word fields
`define WDT_CFG_POST_LSB 0
`define WDT_CFG_PRE_BIT 4
`define WDT_CFG_WIN_BIT 6
`define WDT_CFG_FEN_BIT 7
`define WDT_CFG_RST 8'h40

// ==========================================================
// Reset-control word fields
`define WDT_RC_SWEN_BIT 5
`define WDT_RC_TO_BIT 4
`define WDT_RC_SLEEP_BIT 3
`define WDT_RC_IDLE_BIT 2

// ==========================================================
// Command word fields (write only, self clearing)
`define WDT_CMD_KICK_BIT 0
`define WDT_CMD_SLEEP_BIT 1
`define WDT_CMD_IDLE_BIT 2

// ==========================================================
// Prescaler terminal counts and timing
`define WDT_PRE5_LAST 7'h1f
`define WDT_PRE7_LAST 7'h7f
`define WDT_PRE5_SHIFT 5
`define WDT_PRE7_SHIFT 7
`define WDT_CLK_PERIOD_NS 100
`define WDT_LOW_POWER_RC_CLOCK_PERIOD_NS 31250

`endif

// file: hdl/wdt_pkg.sv
// Types shared by the watchdog design files
package wdt_pkg;

  // ==========================================================
  // Power mode of the core as seen by the watchdog
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_SLEEP = 2'b01,
    PM_IDLE = 2'b10
  } power_mode_t;

  // ==========================================================
  // Configuration word
  typedef struct packed {
    logic force_enable_cfg;
    logic window_disable;
    logic prescale_select;
    logic [3:0] postscale_select;
  } wdt_cfg_t;

  // Reset-control bits held by the block
  typedef struct packed {
    logic soft_enable;
    logic timeout_flag;
    logic sleep_flag;
    logic idle_flag;
  } rst_ctl_t;

  // Events arriving from the rest of the device
  typedef struct packed {
    logic sys_reset;
    logic clk_switch_done;
    logic fscm_switch_done;
    logic wake_event;
  } sys_event_t;

  // State of the slow tick generator
  typedef struct packed {
    logic [8:0] div_cnt;
    logic tick;
  } tick_state_t;

  // State of the watchdog core
  typedef struct packed {
    wdt_cfg_t cfg;
    rst_ctl_t rc;
    power_mode_t mode;
    logic [6:0] pre_cnt;
    logic [15:0] post_cnt;
    logic [31:0] prdata;
    logic dev_reset;
    logic wake;
  } wdt_state_t;

endpackage

// file: hdl/low_power_rc_clock_tick_gen.sv
// Low-power RC clock model: one-cycle tick at the nominal 32 kHz rate
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"

module low_power_rc_clock_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clock_on,
  output logic tick
);

  // Cycles of pclk per slow period, rounded down
  localparam int TICK_CYC = `WDT_LOW_POWER_RC_CLOCK_PERIOD_NS / `WDT_CLK_PERIOD_NS;
  localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);

  wdt_pkg::tick_state_t s_reg; // Registered state
  wdt_pkg::tick_state_t s_next; // Next state

  // ==========================================================
  // Divider
  // Divider restarts whenever the source is off, so the first tick after
  // enabling always comes one full slow period later
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!clock_on) begin
      s_next.div_cnt = 9'h000;
    end else if (s_reg.div_cnt == TICK_LAST) begin
      s_next.div_cnt = 9'h000;
      s_next.tick = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 9'h001;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule
`default_nettype wire

// file: hdl/window_watchdog_timer.sv
// Window watchdog timer with prescaler, postscaler and APB register access
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"

// Behaviour
// - Counter runs on slow RC clock, enable starts it
// - Prescaler divides by 32 or by 128
// - Base timeout 1 ms or 4 ms
// - 4-bit postscaler, ratios 1:1 to 1:32768
// - Device reset zeroes counter and both scalers
// - Completed clock switch clears all counts
// - Entering sleep or idle clears counts
// - Leaving sleep or idle clears counts
// - Kick instruction restarts the timer
// - Timeout in sleep or idle wakes core
// - Timeout flag sticks until software clears it
// - Force-enable bit keeps watchdog always running
// - Otherwise soft enable bit gates running
// - Every device reset clears soft enable
// - Early kick in window mode resets device
// - Prescale bit one selects divide by 128
// - Window bit one selects non-window mode
module window_watchdog_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wdt_pkg::sys_event_t sys_ev,
  output logic low_power_rc_clock_clock_on,
  output logic device_reset,
  output logic wake_core,
  output wdt_pkg::power_mode_t power_mode
);

  // ==========================================================
  // Declarations
  wdt_pkg::wdt_state_t s_reg; // Registered state
  wdt_pkg::wdt_state_t s_next; // Next state
  logic slow_tick; // One pulse per slow RC period
  logic wdt_run; // Watchdog enabled
  logic acc_wr; // Write access phase completes
  logic addr_ok; // Address decodes to a register
  // Reset pattern of the configuration word, split into fields at reset
  localparam logic [7:0] CFG_RST = `WDT_CFG_RST;

  // ==========================================================
  // Helper functions

  // True when the offset is one of the four registers
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `WDT_CFG_OFS) || (a == `WDT_RCTL_OFS) ||
                (a == `WDT_COUNT_OFS) || (a == `WDT_CMD_OFS);
  endfunction

  // Last postscaler count for a ratio of 2 to the power sel
  function automatic logic [15:0] post_last(input logic [3:0] sel);
    post_last = 16'((17'h00001 << sel) - 17'h00001);
  endfunction

  // Last prescaler count for the chosen mode
  function automatic logic [6:0] pre_last(input logic sel);
    pre_last = sel ? `WDT_PRE7_LAST : `WDT_PRE5_LAST;
  endfunction

  // Elapsed time still outside the final quarter of the period
  function automatic logic is_early(input logic [15:0] post, input logic [6:0] pre,
                                    input logic [3:0] sel, input logic pre_sel);
    logic [24:0] elapsed;
    logic [24:0] total;
    elapsed = pre_sel ? {2'b00, post, pre} : {4'h0, post, pre[4:0]};
    total = (25'h0000001 << sel) << (pre_sel ? `WDT_PRE7_SHIFT : `WDT_PRE5_SHIFT);
    // Early while 4 * elapsed < 3 * total
    is_early = (elapsed << 2) < ((total << 1) + total);
  endfunction

  // Read value for an offset
  function automatic logic [31:0] read_word(input wdt_pkg::wdt_state_t st,
                                            input logic [11:0] a);
    read_word = 32'h00000000;
    unique case (a)
      `WDT_CFG_OFS: begin
        read_word[`WDT_CFG_POST_LSB +: 4] = st.cfg.postscale_select;
        read_word[`WDT_CFG_PRE_BIT] = st.cfg.prescale_select;
        read_word[`WDT_CFG_WIN_BIT] = st.cfg.window_disable;
        read_word[`WDT_CFG_FEN_BIT] = st.cfg.force_enable_cfg;
      end
      `WDT_RCTL_OFS: begin
        read_word[`WDT_RC_SWEN_BIT] = st.rc.soft_enable;
        read_word[`WDT_RC_TO_BIT] = st.rc.timeout_flag;
        read_word[`WDT_RC_SLEEP_BIT] = st.rc.sleep_flag;
        read_word[`WDT_RC_IDLE_BIT] = st.rc.idle_flag;
      end
      `WDT_COUNT_OFS: begin
        read_word = {9'h000, st.pre_cnt, st.post_cnt};
      end
      default: begin
        // Command word and unmapped offsets read as zero
        read_word = 32'h00000000;
      end
    endcase
  endfunction

  // ==========================================================
  // Slow clock source
  // force enable overrides soft enable
  assign wdt_run = s_reg.cfg.force_enable_cfg | s_reg.rc.soft_enable;
  // enabling also turns the RC source on
  assign low_power_rc_clock_clock_on = wdt_run;

  low_power_rc_clock_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clock_on(wdt_run),
    .tick(slow_tick)
  );

  // ==========================================================
  // APB handshake
  // Zero wait states; an unmapped offset answers with an error
  // Read data is captured in setup, so no wait state is ever needed
  assign addr_ok = is_mapped(paddr);
  assign acc_wr = psel & penable & pwrite & addr_ok;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = s_reg.prdata;

  // ==========================================================
  // Next-state logic
  // Order matters: register writes first, then counting, then the
  // clearing events, so that hardware sets always win over software clears
  always_comb begin
    logic kick; // Kick command accepted in run mode
    logic go_sleep; // Sleep command accepted
    logic go_idle; // Idle command accepted
    logic expire; // Postscaler reached its end this cycle
    logic early; // Kick came before the open window
    logic clear; // Any cause of a counter restart other than a timeout or a device reset
    logic leave; // Leaving a power-save mode
    kick = 1'b0;
    go_sleep = 1'b0;
    go_idle = 1'b0;
    expire = 1'b0;
    early = 1'b0;
    clear = 1'b0;
    leave = 1'b0;
    s_next = s_reg;
    s_next.dev_reset = 1'b0;
    s_next.wake = 1'b0;

    // Read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      s_next.prdata = read_word(s_reg, paddr);
    end

    // Register writes
    if (acc_wr && paddr == `WDT_CFG_OFS) begin
      s_next.cfg.postscale_select = pwdata[`WDT_CFG_POST_LSB +: 4];
      s_next.cfg.prescale_select = pwdata[`WDT_CFG_PRE_BIT];
      s_next.cfg.window_disable = pwdata[`WDT_CFG_WIN_BIT];
      s_next.cfg.force_enable_cfg = pwdata[`WDT_CFG_FEN_BIT];
    end
    if (acc_wr && paddr == `WDT_RCTL_OFS) begin
      s_next.rc.soft_enable = pwdata[`WDT_RC_SWEN_BIT];
      // flags only clear by writing zero
      s_next.rc.timeout_flag = s_reg.rc.timeout_flag & pwdata[`WDT_RC_TO_BIT];
      // software clears sleep and idle flags
      s_next.rc.sleep_flag = s_reg.rc.sleep_flag & pwdata[`WDT_RC_SLEEP_BIT];
      s_next.rc.idle_flag = s_reg.rc.idle_flag & pwdata[`WDT_RC_IDLE_BIT];
    end
    if (acc_wr && paddr == `WDT_CMD_OFS && s_reg.mode == wdt_pkg::PM_RUN) begin
      kick = pwdata[`WDT_CMD_KICK_BIT];
      go_sleep = pwdata[`WDT_CMD_SLEEP_BIT];
      go_idle = pwdata[`WDT_CMD_IDLE_BIT] & ~pwdata[`WDT_CMD_SLEEP_BIT];
    end

    // prescaler then postscaler, counting on slow ticks
    // wrap of 32 or 128 slow periods gives 1 ms or 4 ms
    if (wdt_run && slow_tick) begin
      if (s_reg.pre_cnt == pre_last(s_reg.cfg.prescale_select)) begin
        s_next.pre_cnt = 7'h00;
        // postscaler ratio of 2 to the power select
        if (s_reg.post_cnt == post_last(s_reg.cfg.postscale_select)) begin
          s_next.post_cnt = 16'h0000;
          expire = 1'b1;
        end else begin
          s_next.post_cnt = s_reg.post_cnt + 16'h0001;
        end
      end else begin
        s_next.pre_cnt = s_reg.pre_cnt + 7'h01;
      end
    end

    // early kick in window mode
    // Only a running watchdog can object to a kick; a stopped one has no period
    early = kick & wdt_run & ~s_reg.cfg.window_disable &
            is_early(s_reg.post_cnt, s_reg.pre_cnt, s_reg.cfg.postscale_select,
                     s_reg.cfg.prescale_select);

    // Leaving sleep or idle by another wake source
    leave = (s_reg.mode != wdt_pkg::PM_RUN) && sys_ev.wake_event;

    // clock switch from software or the fail-safe monitor
    // kick restarts the count
    // Disabling counts as a clear, so enabling always starts a full period
    clear = kick | go_sleep | go_idle | sys_ev.clk_switch_done |
            sys_ev.fscm_switch_done | leave | ~wdt_run;

    // Power-save entry
    // Sleep wins when both command bits are set
    if (go_sleep) begin
      s_next.mode = wdt_pkg::PM_SLEEP;
      s_next.rc.sleep_flag = 1'b1;
    end else if (go_idle) begin
      s_next.mode = wdt_pkg::PM_IDLE;
      s_next.rc.idle_flag = 1'b1;
    end
    if (leave) begin
      s_next.mode = wdt_pkg::PM_RUN;
    end

    if (clear) begin
      s_next.pre_cnt = 7'h00;
      s_next.post_cnt = 16'h0000;
    end

    // Timeout handling; a tick expiring together with a clear is dropped
    // The wake path clears counts itself, as no clear is pending then
    if (expire && !clear && s_reg.mode != wdt_pkg::PM_RUN) begin
      // timeout in sleep or idle wakes the core
      s_next.wake = 1'b1;
      s_next.mode = wdt_pkg::PM_RUN;
      s_next.rc.timeout_flag = 1'b1;
      s_next.pre_cnt = 7'h00;
      s_next.post_cnt = 16'h0000;
    end else if ((expire && !clear) || early) begin
      s_next.dev_reset = 1'b1;
      // flag set by hardware and held
      s_next.rc.timeout_flag = 1'b1;
    end

    // Device reset from the watchdog or from elsewhere
    if (s_next.dev_reset || sys_ev.sys_reset) begin
      // counter and scalers return to zero
      s_next.pre_cnt = 7'h00;
      s_next.post_cnt = 16'h0000;
      s_next.mode = wdt_pkg::PM_RUN;
      s_next.rc.soft_enable = 1'b0;
      // A reset overrides any wake raised in the same cycle
      s_next.wake = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // asynchronous reset zeroes all counts
  // Frozen while ce is low, so a stalled clock loses no count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Field by field, since the register word has an unused bit 5
      // that the packed struct lacks, so the bit positions differ
      s_reg.cfg.postscale_select <= CFG_RST[`WDT_CFG_POST_LSB +: 4];
      s_reg.cfg.prescale_select <= CFG_RST[`WDT_CFG_PRE_BIT];
      s_reg.cfg.window_disable <= CFG_RST[`WDT_CFG_WIN_BIT];
      s_reg.cfg.force_enable_cfg <= CFG_RST[`WDT_CFG_FEN_BIT];
      s_reg.rc <= '0;
      s_reg.mode <= wdt_pkg::PM_RUN;
      s_reg.pre_cnt <= 7'h00;
      s_reg.post_cnt <= 16'h0000;
      s_reg.prdata <= 32'h00000000;
      s_reg.dev_reset <= 1'b0;
      s_reg.wake <= 1'b0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  // Straight from flops, so the device reset line never glitches
  assign device_reset = s_reg.dev_reset;
  assign wake_core = s_reg.wake;
  assign power_mode = s_reg.mode;

endmodule
`default_nettype wire

// file: sim/window_watchdog_timer_chk.sv
// Port-level assertions for the window watchdog
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"

// ==========================================================
// Checker module
module window_watchdog_timer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire wdt_pkg::sys_event_t sys_ev,
  input wire logic low_power_rc_clock_clock_on,
  input wire logic device_reset,
  input wire logic wake_core,
  input wire wdt_pkg::power_mode_t power_mode
);
  // Single domain, so one clocking and one disable
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Address hits one of the four words
  logic mapped;
  assign mapped = paddr inside {`WDT_CFG_OFS, `WDT_RCTL_OFS, `WDT_COUNT_OFS, `WDT_CMD_OFS};

  // ==========================================================
  // Bus phases
  sequence rd_setup_s;
    psel && !penable && !pwrite && ce;
  endsequence
  sequence cmd_wr_s;
    psel && penable && pwrite && ce && paddr == `WDT_CMD_OFS;
  endsequence

  // ==========================================================
  // Assertions
  pready_high_a: assert property (pready) else $error("pready low");
  slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  slverr_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  zero_read_a: assert property (rd_setup_s ##0 (paddr == `WDT_CMD_OFS || !mapped) |=> prdata == 0)
    else $error("read data not zero");
  reset_pulse_a: assert property (device_reset && ce |=> !device_reset)
    else $error("device reset longer than one cycle");
  wake_pulse_a: assert property (wake_core && ce |=> !wake_core)
    else $error("wake longer than one cycle");
  wake_to_run_a: assert property ($rose(wake_core) |-> power_mode == wdt_pkg::PM_RUN && $past(power_mode) != wdt_pkg::PM_RUN)
    else $error("wake without leaving power save");
  reset_when_on_a: assert property (device_reset |-> $past(power_mode) == wdt_pkg::PM_RUN && $past(low_power_rc_clock_clock_on))
    else $error("device reset while off or saving");
  save_by_cmd_a: assert property (power_mode != wdt_pkg::PM_RUN && $past(power_mode) == wdt_pkg::PM_RUN |-> $past(psel && penable && pwrite && paddr == `WDT_CMD_OFS))
    else $error("power save entered without command");
  sleep_cmd_a: assert property (cmd_wr_s ##0 (pwdata[`WDT_CMD_SLEEP_BIT] && !sys_ev.sys_reset && power_mode == wdt_pkg::PM_RUN) |=> power_mode == wdt_pkg::PM_SLEEP)
    else $error("sleep command not taken");
  sysrst_run_a: assert property (sys_ev.sys_reset && ce |=> power_mode == wdt_pkg::PM_RUN && !wake_core)
    else $error("system reset did not return to run");
endmodule

bind window_watchdog_timer window_watchdog_timer_chk chk_i (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_ev(sys_ev),
  .low_power_rc_clock_clock_on(low_power_rc_clock_clock_on), .device_reset(device_reset), .wake_core(wake_core),
  .power_mode(power_mode));
`default_nettype wire

// file: sim/tb_window_watchdog_timer.sv
// Self-checking bench for the window watchdog over its APB port
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

// ==========================================================
// Bench top
module tb_window_watchdog_timer;
  // Slow tick period and base timeout in pclk cycles
  localparam int SLOW = `WDT_LOW_POWER_RC_CLOCK_PERIOD_NS / `WDT_CLK_PERIOD_NS;
  localparam int TO = SLOW * 32;
  // Tick phase is not known exactly, so allow a margin
  localparam int SLACK = 400;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic low_power_rc_clock_clock_on, device_reset, wake_core, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, d0;
  wdt_pkg::sys_event_t sys_ev;
  wdt_pkg::power_mode_t power_mode;
  int errors, n_checks;

  window_watchdog_timer uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_ev(sys_ev), .low_power_rc_clock_clock_on(low_power_rc_clock_clock_on),
    .device_reset(device_reset), .wake_core(wake_core), .power_mode(power_mode));

  // ==========================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #(100_000 * 100);
    errors++;
    complete_run();
  end

  // ==========================================================
  // Tasks
  // One APB transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Return at the falling edge, so outputs launched by the access edge have settled
    @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(d, exp)
  endtask
  // One-cycle event pulse; idx 3 reset, 2 switch, 1 monitor, 0 wake
  task automatic pulse(input int idx);
    @(posedge pclk);
    sys_ev <= wdt_pkg::sys_event_t'(4'h1 << idx);
    @(posedge pclk);
    sys_ev <= '0;
    @(negedge pclk);
  endtask
  // Pulse must not come before lo cycles and must come before hi
  task automatic expect_pulse(input logic wk, input int lo, input int hi);
    int t;
    for (t = 0; t < hi; t++) begin
      @(posedge pclk);
      if ((wk ? wake_core : device_reset) === 1'b1) break;
    end
    `CHK(t >= lo && t < hi, 1'b1)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sys_ev = '0;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped access
    rdc(`WDT_CFG_OFS, 32'h40);
    rdc(`WDT_RCTL_OFS, 32'h0);
    rdc(12'h010, 32'h0);
    `CHK(e, 1'b1)
    rdc(`WDT_CMD_OFS, 32'h0);
    $display("test reset done");
    // Run-mode timeout, sticky flag
    wr(`WDT_RCTL_OFS, 32'h20);
    `CHK(low_power_rc_clock_clock_on, 1'b1)
    expect_pulse(1'b0, TO - SLACK, TO + SLACK);
    rdc(`WDT_RCTL_OFS, 32'h10);
    repeat (50) @(posedge pclk);
    rdc(`WDT_RCTL_OFS, 32'h10);
    wr(`WDT_RCTL_OFS, 32'h0);
    rdc(`WDT_RCTL_OFS, 32'h0);
    $display("test timeout done");
    // Kick pushes the timeout out
    wr(`WDT_RCTL_OFS, 32'h20);
    repeat (3000) @(posedge pclk);
    wr(`WDT_CMD_OFS, 32'h1);
    expect_pulse(1'b0, TO - SLACK, TO + SLACK);
    wr(`WDT_RCTL_OFS, 32'h0);
    $display("test kick done");
    // Clock switch, monitor switch and system reset clear counts
    for (int i = 2; i >= 1; i--) begin
      wr(`WDT_RCTL_OFS, 32'h20);
      repeat (2000) @(posedge pclk);
      apb(1'b0, `WDT_COUNT_OFS, 32'h0);
      `CHK(d != 0, 1'b1)
      pulse(i);
      apb(1'b0, `WDT_COUNT_OFS, 32'h0);
      `CHK(d < 32'h2, 1'b1)
    end
    pulse(3);
    rdc(`WDT_RCTL_OFS, 32'h0);
    rdc(`WDT_COUNT_OFS, 32'h0);
    `CHK(low_power_rc_clock_clock_on, 1'b0)
    $display("test clears done");
    // Forced enable ignores the soft bit
    wr(`WDT_CFG_OFS, 32'hc0);
    `CHK(low_power_rc_clock_clock_on, 1'b1)
    repeat (500) @(posedge pclk);
    apb(1'b0, `WDT_COUNT_OFS, 32'h0);
    `CHK(d != 0, 1'b1)
    // Clock enable low freezes the counts and the tick divider
    d0 = d;
    @(posedge pclk);
    ce <= 1'b0;
    repeat (400) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, `WDT_COUNT_OFS, 32'h0);
    `CHK(d, d0)
    wr(`WDT_CFG_OFS, 32'h40);
    `CHK(low_power_rc_clock_clock_on, 1'b0)
    $display("test force done");
    // Sleep entry, timeout wake, idle exit by wake event
    wr(`WDT_RCTL_OFS, 32'h20);
    repeat (2000) @(posedge pclk);
    wr(`WDT_CMD_OFS, 32'h2);
    `CHK(power_mode, wdt_pkg::PM_SLEEP)
    apb(1'b0, `WDT_COUNT_OFS, 32'h0);
    `CHK(d < 32'h2, 1'b1)
    expect_pulse(1'b1, TO - SLACK, TO + SLACK);
    `CHK(power_mode, wdt_pkg::PM_RUN)
    rdc(`WDT_RCTL_OFS, 32'h38);
    // Software clears the save flags after waking
    wr(`WDT_RCTL_OFS, 32'h20);
    wr(`WDT_CMD_OFS, 32'h4);
    `CHK(power_mode, wdt_pkg::PM_IDLE)
    repeat (2000) @(posedge pclk);
    pulse(0);
    `CHK(power_mode, wdt_pkg::PM_RUN)
    apb(1'b0, `WDT_COUNT_OFS, 32'h0);
    `CHK(d < 32'h2, 1'b1)
    wr(`WDT_RCTL_OFS, 32'h0);
    $display("test power save done");
    // Window mode: early kick resets, late kick restarts
    wr(`WDT_CFG_OFS, 32'h00);
    wr(`WDT_RCTL_OFS, 32'h20);
    repeat (100) @(posedge pclk);
    wr(`WDT_CMD_OFS, 32'h1);
    expect_pulse(1'b0, 0, 10);
    rdc(`WDT_RCTL_OFS, 32'h10);
    wr(`WDT_RCTL_OFS, 32'h20);
    repeat (8000) @(posedge pclk);
    // Kick placed inside the last quarter
    wr(`WDT_CMD_OFS, 32'h1);
    expect_pulse(1'b0, TO - SLACK, TO + SLACK);
    wr(`WDT_RCTL_OFS, 32'h0);
    $display("test window done");
    // Prescale /128 then /32 with postscale 1:2
    wr(`WDT_CFG_OFS, 32'h51);
    wr(`WDT_RCTL_OFS, 32'h20);
    repeat (36 * SLOW + 100) @(posedge pclk);
    apb(1'b0, `WDT_COUNT_OFS, 32'h0);
    `CHK(d[22:16] >= 7'd35 && d[22:16] <= 7'd37 && d[15:0] == 16'h0, 1'b1)
    wr(`WDT_RCTL_OFS, 32'h0);
    wr(`WDT_CFG_OFS, 32'h41);
    wr(`WDT_RCTL_OFS, 32'h20);
    repeat (36 * SLOW + 100) @(posedge pclk);
    apb(1'b0, `WDT_COUNT_OFS, 32'h0);
    `CHK(d[22:16] >= 7'd3 && d[22:16] <= 7'd5, 1'b1)
    `CHK(d[15:0], 16'h1)
    wr(`WDT_RCTL_OFS, 32'h0);
    $display("test scaling done");
    complete_run();
  end
endmodule
`default_nettype wire
